// File: verilog/tloe_defs.svh
// Constants of the three-level optical line encoder: level codes and timing.
// Assumes a 50 MHz clock; the cycle counts are derived from it here.
`ifndef TLOE_DEFS_SVH
`define TLOE_DEFS_SVH

`define TLOE_CLOCK_HZ 50000000
`define TLOE_PULSE_NS 40
`define TLOE_REPEAT_HZ 300000
// Pulse width rounds down so a pulse never exceeds its nominal length.
`define TLOE_PULSE_CYCLES \
	((`TLOE_PULSE_NS * (`TLOE_CLOCK_HZ / 1000000)) / 1000)
// The repetition interval rounds down as well; 166 cycles at 50 MHz.
`define TLOE_REPEAT_CYCLES (`TLOE_CLOCK_HZ / `TLOE_REPEAT_HZ)
`define TLOE_LEVEL_LOW 2'h0
`define TLOE_LEVEL_MID 2'h1
`define TLOE_LEVEL_HIGH 2'h2

`endif

// File: verilog/tloe_pkg.sv
// Types shared by the three-level optical line encoder.
// Assumes tloe_defs.svh supplies the level codes.
`include "tloe_defs.svh"

package tloe_pkg;

	typedef logic [1:0] tloe_level_type;

	typedef struct packed {
		logic data;
		logic mode;
	} tloe_input_type;

	typedef enum logic {
		tloe_idle,
		tloe_pulse
	} tloe_phase_type;

endpackage : tloe_pkg

// File: verilog/tloe_sync.sv
// Two-flip-flop synchroniser for the data and mode pins.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ps

module tloe_sync (
	input wire logic clock,
	input wire logic reset,
	input wire tloe_pkg::tloe_input_type pins,
	output tloe_pkg::tloe_input_type synced
);
	import tloe_pkg::*;

	tloe_input_type stage;
	tloe_input_type next_stage;
	tloe_input_type next_synced;

	always_comb begin
		next_stage = pins;
		next_synced = stage;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stage <= '0;
			synced <= '0;
		end else begin
			stage <= next_stage;
			synced <= next_synced;
		end
	end

endmodule : tloe_sync

// File: verilog/tloe_encoder.sv
// Three-level optical line encoder: drives a two-bit optical level code.
// Assumes data and mode are host pins; the data pin holds each level for
// at least 100 ns.
`timescale 1ns/1ps
`include "tloe_defs.svh"

// Function
// [R1] Mode low selects three-level, high replica.
// [R2] Mid level between pulses; pulse polarity follows data.
// [R3] Data edges start pulse trains of matching polarity.
// [R4] Pulses about 40 ns, repeating at 300 kHz.
// [R5] New train starts immediately with full pulse.
// [R6] Data change cuts pulse, starts opposite train.
// [R7] Refresh pulses continue without limit while data steady.
// [R8] Host holds data levels at least 100 ns.
// [R9] Replica mode: high for data high, else low.
// [R10] Replica mode needs host-side line coding.
// [R11] Two-bit level code; timing by counting cycles.
module tloe_encoder #(
	parameter int pulse_cycles = `TLOE_PULSE_CYCLES,
	parameter int repeat_cycles = `TLOE_REPEAT_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic data,
	input wire logic mode,
	output tloe_pkg::tloe_level_type level
);
	import tloe_pkg::*;

	tloe_input_type pins;
	tloe_input_type synced;
	logic last_data;
	logic next_last_data;
	tloe_phase_type phase;
	tloe_phase_type next_phase;
	logic [7:0] count;
	logic [7:0] next_count;
	tloe_level_type next_level;
	logic data_edge;

	assign pins = '{data: data, mode: mode};

	tloe_sync sync_inst (
		.clock(clock),
		.reset(reset),
		.pins(pins),
		.synced(synced)
	);

	assign data_edge = synced.data != last_data;

	// The count runs over the whole repetition interval; the pulse occupies
	// its first cycles. A data edge restarts the interval at zero. [R11]
	always_comb begin
		next_last_data = synced.data;
		next_phase = phase;
		next_count = count;
		next_level = `TLOE_LEVEL_MID;
		if (data_edge) begin
			next_count = 8'h00; // [R5] [R6]
			next_phase = tloe_pulse; // [R3]
		end else if (count == 8'(repeat_cycles - 1)) begin
			next_count = 8'h00; // [R7]
			next_phase = tloe_pulse;
		end else begin
			next_count = count + 8'h01;
			if (count == 8'(pulse_cycles - 1)) begin
				next_phase = tloe_idle; // [R4]
			end
		end
		if (synced.mode) begin
			// Replica mode ignores the pulse machine entirely. [R1] [R9]
			next_level = synced.data ? `TLOE_LEVEL_HIGH : `TLOE_LEVEL_LOW;
		end else begin
			case (next_phase)
				tloe_pulse: begin
					next_level = synced.data ? `TLOE_LEVEL_HIGH
						: `TLOE_LEVEL_LOW; // [R2]
				end
				tloe_idle: begin
					next_level = `TLOE_LEVEL_MID; // [R2]
				end
				default: begin
					next_level = `TLOE_LEVEL_MID;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			last_data <= 1'b0;
			phase <= tloe_idle;
			count <= 8'h00;
			level <= `TLOE_LEVEL_MID;
		end else begin
			last_data <= next_last_data;
			phase <= next_phase;
			count <= next_count;
			level <= next_level;
		end
	end

	// Assertion helper: how many cycles the output has stood at one
	// excursion level that the three-level path produced. Counting the
	// registered output rather than the phase also catches a pulse that
	// the next-state logic stretches by mistake.
	logic level_coded;
	logic next_level_coded;
	logic [7:0] excursion_run;
	logic [7:0] next_excursion_run;

	always_comb begin
		next_level_coded = !synced.mode;
		next_excursion_run = 8'h00;
		if (next_level_coded && next_level != `TLOE_LEVEL_MID) begin
			if (level_coded && next_level == level) begin
				next_excursion_run = excursion_run + 8'h01;
			end else begin
				next_excursion_run = 8'h01;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			level_coded <= 1'b0;
			excursion_run <= 8'h00;
		end else begin
			level_coded <= next_level_coded;
			excursion_run <= next_excursion_run;
		end
	end

	property p_edge_pulse;
		@(posedge clock) disable iff (reset)
		(!synced.mode && data_edge) |=>
			(level == (synced.data ? `TLOE_LEVEL_HIGH : `TLOE_LEVEL_LOW));
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) // [R3]
		else $error("Pulse did not start on data edge.");

	property p_full_pulse;
		@(posedge clock) disable iff (reset)
		(!synced.mode && data_edge) ##1 (!data_edge && !synced.mode) [*2]
			|-> (level != `TLOE_LEVEL_MID);
	endproperty
	a_full_pulse: assert property (p_full_pulse) // [R5]
		else $error("Pulse shorter than full duration.");

	property p_pulse_ends;
		@(posedge clock) disable iff (reset)
		(phase == tloe_pulse && count == 8'(pulse_cycles - 1) && !data_edge
			&& !synced.mode) |=> (level == `TLOE_LEVEL_MID);
	endproperty
	a_pulse_ends: assert property (p_pulse_ends) // [R4]
		else $error("Pulse exceeded its width.");

	property p_repeat;
		@(posedge clock) disable iff (reset)
		(count == 8'(repeat_cycles - 1) && !data_edge && !synced.mode
			&& $stable(synced.data)) |=> (level != `TLOE_LEVEL_MID);
	endproperty
	a_repeat: assert property (p_repeat) // [R7]
		else $error("Refresh pulse not repeated.");

	property p_replica;
		@(posedge clock) disable iff (reset)
		synced.mode |=> (level == ($past(synced.data) ? `TLOE_LEVEL_HIGH
			: `TLOE_LEVEL_LOW));
	endproperty
	a_replica: assert property (p_replica) // [R9]
		else $error("Replica level wrong.");

	property p_polarity;
		@(posedge clock) disable iff (reset)
		(!synced.mode && level == `TLOE_LEVEL_HIGH) |-> $past(synced.data);
	endproperty
	a_polarity: assert property (p_polarity) // [R2]
		else $error("Pulse polarity against data.");

	property p_restart;
		@(posedge clock) disable iff (reset)
		data_edge |=> (count == 8'h00);
	endproperty
	a_restart: assert property (p_restart) // [R6]
		else $error("Train not restarted on data change.");

	property p_mode_low;
		@(posedge clock) disable iff (reset)
		(!synced.mode && phase == tloe_idle && !data_edge
			&& count != 8'(repeat_cycles - 1)) |=> (level == `TLOE_LEVEL_MID);
	endproperty
	a_mode_low: assert property (p_mode_low) // [R1]
		else $error("Mid level missing in three-level mode.");

	property p_cut_pulse;
		@(posedge clock) disable iff (reset)
		(!synced.mode && data_edge && level != `TLOE_LEVEL_MID)
			|=> (level != `TLOE_LEVEL_MID && level != $past(level));
	endproperty
	a_cut_pulse: assert property (p_cut_pulse) // [R6]
		else $error("Pulse not cut on data change.");

	property p_count_range;
		@(posedge clock) disable iff (reset)
		count <= 8'(repeat_cycles - 1);
	endproperty
	a_count_range: assert property (p_count_range) // [R11]
		else $error("Interval count out of range.");

	property p_replica_level;
		@(posedge clock) disable iff (reset)
		synced.mode |=> (level != `TLOE_LEVEL_MID);
	endproperty
	a_replica_level: assert property (p_replica_level) // [R9]
		else $error("Mid level in replica mode.");

	property p_pulse_width;
		@(posedge clock) disable iff (reset)
		excursion_run <= 8'(pulse_cycles);
	endproperty
	a_pulse_width: assert property (p_pulse_width) // [R4]
		else $error("Excursion stood longer than a pulse.");

	c_rise: cover property (@(posedge clock) disable iff (reset)
		!synced.mode && data_edge && synced.data);
	c_fall: cover property (@(posedge clock) disable iff (reset)
		!synced.mode && data_edge && !synced.data);
	c_repeat: cover property (@(posedge clock) disable iff (reset)
		!synced.mode && count == 8'(repeat_cycles - 1));
	c_replica: cover property (@(posedge clock) disable iff (reset)
		synced.mode && level == `TLOE_LEVEL_HIGH);
	c_cut: cover property (@(posedge clock) disable iff (reset)
		!synced.mode && data_edge && level != `TLOE_LEVEL_MID);

endmodule : tloe_encoder

// File: tb/tloe_rx_model.sv
// Behavioural receiver at the far end of the fiber.
// Assumes level is the encoder's registered optical level code.
`timescale 1ns/1ps
`include "tloe_defs.svh"

module tloe_rx_model (
	input wire logic clock,
	input wire tloe_pkg::tloe_level_type level,
	output logic rx_data
);
	import tloe_pkg::*;
	// Mid level carries no news, so the last excursion is held.
	always_ff @(posedge clock) begin
		if (level == `TLOE_LEVEL_HIGH) rx_data <= 1'b1;
		else if (level == `TLOE_LEVEL_LOW) rx_data <= 1'b0;
	end
endmodule : tloe_rx_model

// File: tb/tloe_encoder_tb.sv
// Self-checking bench for the line encoder with a small repeat interval.
// Assumes the receiver model sits on the optical side.
`timescale 1ns/1ps
`include "tloe_defs.svh"

module tloe_encoder_tb;
	import tloe_pkg::*;
	typedef struct {
		logic d;
		logic m;
		int n;
		tloe_level_type e;
	} tloe_row_type;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic data = 1'b0;
	logic mode = 1'b0;
	logic rx_data;
	tloe_level_type level;
	int err_count = 0;
	int check_count = 0;
	tloe_row_type rows [9];
	tloe_encoder #(.pulse_cycles(2), .repeat_cycles(10)) u_dut (
		.clock(clock),
		.reset(reset),
		.data(data),
		.mode(mode),
		.level(level)
	);
	tloe_rx_model u_rx (.clock(clock), .level(level), .rx_data(rx_data));
	initial begin
		forever #10 clock = ~clock;
	end
	task automatic check(input tloe_level_type seen, input tloe_level_type exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	initial begin
		#(200 * 20);
		err_count++;
		conclude();
	end
	initial begin
		// Every level is held at least five cycles, as the host must.
		rows = '{
			'{1'b1, 1'b0, 3, `TLOE_LEVEL_HIGH},
			'{1'b1, 1'b0, 1, `TLOE_LEVEL_HIGH},
			'{1'b1, 1'b0, 1, `TLOE_LEVEL_MID},
			'{1'b1, 1'b0, 8, `TLOE_LEVEL_HIGH},
			'{1'b0, 1'b0, 3, `TLOE_LEVEL_LOW},
			'{1'b0, 1'b0, 1, `TLOE_LEVEL_LOW},
			'{1'b0, 1'b0, 1, `TLOE_LEVEL_MID},
			'{1'b1, 1'b1, 5, `TLOE_LEVEL_HIGH},
			'{1'b0, 1'b1, 5, `TLOE_LEVEL_LOW}};
		step(2);
		reset = 1'b0;
		foreach (rows[i]) begin
			data = rows[i].d;
			mode = rows[i].m;
			step(rows[i].n);
			check(level, rows[i].e);
			if (i == 6) check({1'b0, rx_data}, 2'h0);
		end
		$display("Row tests done");
		// A second reset mid-run, released with the data pin high.
		reset = 1'b1;
		mode = 1'b0;
		data = 1'b1;
		#1;
		check(level, `TLOE_LEVEL_MID);
		step(1);
		reset = 1'b0;
		step(2);
		check(level, `TLOE_LEVEL_MID);
		step(1);
		check(level, `TLOE_LEVEL_HIGH);
		$display("Reset test done");
		// Data falls two cycles before a refresh pulse, so the change
		// reaches the encoder while that pulse stands and cuts it.
		step(8);
		check(level, `TLOE_LEVEL_MID);
		data = 1'b0;
		step(2);
		check(level, `TLOE_LEVEL_HIGH);
		step(1);
		check(level, `TLOE_LEVEL_LOW);
		step(1);
		check(level, `TLOE_LEVEL_LOW);
		step(1);
		check(level, `TLOE_LEVEL_MID);
		check({1'b0, rx_data}, 2'h0);
		$display("Cut pulse test done");
		conclude();
	end
endmodule : tloe_encoder_tb
